// ==== rtl/kpl_key_power_latch.v ====
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Operation
// - Filtered key high powers up; relay driver comes before the regulators.
// - Relay mode: bias comes with the relay; regulators wait for battery out of undervoltage.
// - Five-volt and tracking supplies a regulator delay after enable in the bias state.
// - Three-volt one millisecond after five-volt is good.
// - Permanent mode: bias on raw key, regulators after filter.
// - Enable = (key or latch without timeout) and battery ok.
// - Key low, latch inactive: off after filter time.
// - Active latch keeps power until software releases it or the selected latch timeout expires.
// - Latch timeout forces off; three-bit field selects it.
// - Raw and filtered key bits are readable.
// - All supplies drop together at power down.
// - Regulator hold 0 drops regulators with relay; 1 keeps them.
// - Held regulators run until battery undervoltage or regulator hold is cleared.
// - No latch or hold: key-off cuts injectors and starters.
// - Starters cut after hold delay only if still engine-off.
// - Hold granted after qualifying key-on time; re-armed each event.
// - Four or more watchdog errors withhold the hold; errors after arming leave it armed.
// - Hold touches only injector and starter drivers.
// - Key fall starts internal hold timer, about 225 ms.
// - Software still switches drivers during hold; configurable.
// - Key return during latch with option set pulses reset.
`include "kpl_defs.vh"
module kpl_key_power_latch #(
   parameter integer KEY_FLT_CYC = `KPL_KEY_FLT_MS * `KPL_CYC_PER_MS,
   parameter integer REG_DLY_CYC = `KPL_REG_DLY_US * `KPL_CYC_PER_US,
   parameter integer V3_DLY_CYC  = `KPL_V3_DLY_US * `KPL_CYC_PER_US,
   parameter integer HOLD_CYC    = `KPL_HOLD_MS * `KPL_CYC_PER_MS,
   parameter integer INJ_ARM_CYC = `KPL_INJ_ARM_MS * `KPL_CYC_PER_MS,
   parameter integer STR_ARM_CYC = `KPL_STR_ARM_MS * `KPL_CYC_PER_MS,
   parameter integer PULSE_CYC   = `KPL_PULSE_US * `KPL_CYC_PER_US,
   parameter integer TO_UNIT_CYC = 100 * `KPL_CYC_PER_MS,
   parameter integer CNT_W       = 32
) (
   input  wire                   i_ref_clk,
   input  wire                   i_sys_rst,
   input  wire                   i_key_above,
   input  wire                   i_battery_not_undervoltage,
   input  wire                   i_five_volt_not_undervoltage,
   input  wire                   i_wd_err_ge4,
   input  wire [3:0]             i_inj_cmd,
   input  wire [1:0]             i_str_cmd,
   input  wire [`KPL_ADDR_W-1:0] i_addr,
   input  wire [7:0]             i_wdata,
   input  wire                   i_wr,
   input  wire                   i_rd,
   output reg  [7:0]             o_rdata,
   output wire                   o_main_relay_driver,
   output wire                   o_bias_en,
   output wire                   o_five_volt_regulator,
   output wire                   o_three_volt_regulator,
   output wire                   o_sensor_tracking_supply,
   output wire                   o_reset_n,
   output wire [3:0]             o_inj_drv,
   output wire [1:0]             o_str_drv
);
   // ****************
   // States
   // ****************
   localparam [2:0] ST_OFF   = 3'h0;
   localparam [2:0] ST_BIAS  = 3'h1;
   localparam [2:0] ST_REGDL = 3'h2;
   localparam [2:0] ST_V3DL  = 3'h3;
   localparam [2:0] ST_ON    = 3'h4;
   localparam [2:0] ST_HOLD  = 3'h5;

   reg  [2:0]       st_r;
   reg  [2:0]       st_nxt;
   reg  [CNT_W-1:0] cnt_r;
   reg  [CNT_W-1:0] cnt_nxt;
   reg  [CNT_W-1:0] to_cnt_r;
   reg  [CNT_W-1:0] pulse_cnt_r;
   reg  [7:0]       ctrl_r;
   reg  [7:0]       cfg6_r;
   reg              to_exp_r;
   reg              krr_pulse_r;
   reg              key_flt_d_r;
   reg              bat_m_r;
   reg              bat_s_r;
   reg              v5_m_r;
   reg              v5_s_r;
   reg              wd_m_r;
   reg              wd_s_r;
   wire             key_raw;
   wire             key_flt;
   wire             latch_act;
   wire             enable;
   wire             inj_hold;
   wire             str_hold;
   wire [2:0]       to_sel;
   wire [CNT_W-1:0] to_lim;

   // ****************
   // Input conditioning
   // ****************
   kpl_sync_filter #(
      .FLT_CYC (KEY_FLT_CYC),
      .CNT_W   (CNT_W)
   ) u_key (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_key_above),
      .o_sync    (key_raw),
      .o_filt    (key_flt)
   );

   // Analog comparators live outside this clock, hence two stages
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         bat_m_r <= 1'b0;
         bat_s_r <= 1'b0;
         v5_m_r  <= 1'b0;
         v5_s_r  <= 1'b0;
         wd_m_r  <= 1'b0;
         wd_s_r  <= 1'b0;
      end else begin
         bat_m_r <= i_battery_not_undervoltage;
         bat_s_r <= bat_m_r;
         v5_m_r  <= i_five_volt_not_undervoltage;
         v5_s_r  <= v5_m_r;
         wd_m_r  <= i_wd_err_ge4;
         wd_s_r  <= wd_m_r;
      end
   end

   // ****************
   // Global enable and latch timeout
   // ****************
   assign latch_act = ~ctrl_r[`KPL_CTRL_LATCH_N];
   assign enable    = (key_flt | (latch_act & ~to_exp_r)) & bat_s_r;
   assign to_sel    = ctrl_r[`KPL_CTRL_TO_LSB +: 3];
   // Select 0 disables the timeout; n gives n units of TO_UNIT_CYC
   assign to_lim    = to_sel * TO_UNIT_CYC[CNT_W-1:0];

   // Timeout runs only while the latch alone keeps the device alive
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         to_cnt_r <= {CNT_W{1'b0}};
         to_exp_r <= 1'b0;
      end else if (~latch_act | key_flt) begin
         to_cnt_r <= {CNT_W{1'b0}};
         to_exp_r <= 1'b0;
      end else if ((to_sel != 3'h0) & ~to_exp_r) begin
         if (to_cnt_r >= to_lim - 1'b1)
            to_exp_r <= 1'b1;
         else
            to_cnt_r <= to_cnt_r + 1'b1;
      end
   end

   // ****************
   // Power sequencer
   // ****************
   always @* begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r + 1'b1;
      case (st_r)
         ST_OFF: begin
            cnt_nxt = {CNT_W{1'b0}};
            if (key_flt | (ctrl_r[`KPL_CTRL_PERM] & key_raw & bat_s_r))
               st_nxt = ST_BIAS;
         end
         ST_BIAS: begin
            cnt_nxt = {CNT_W{1'b0}};
            // Relay must close before battery can be seen, so wait on key only
            if (~key_flt & ~(ctrl_r[`KPL_CTRL_PERM] & key_raw))
               st_nxt = ST_OFF;
            else if (enable)
               st_nxt = ST_REGDL;
         end
         ST_REGDL: begin
            if (cnt_r == REG_DLY_CYC[CNT_W-1:0] - 1'b1) begin
               st_nxt  = ST_V3DL;
               cnt_nxt = {CNT_W{1'b0}};
            end
         end
         ST_V3DL: begin
            if (~v5_s_r)
               cnt_nxt = {CNT_W{1'b0}};
            else if (cnt_r == V3_DLY_CYC[CNT_W-1:0] - 1'b1)
               st_nxt = ST_ON;
         end
         ST_ON: begin
            cnt_nxt = {CNT_W{1'b0}};
         end
         ST_HOLD: begin
            cnt_nxt = {CNT_W{1'b0}};
            if (~ctrl_r[`KPL_CTRL_REG_HOLD] | ~bat_s_r)
               st_nxt = ST_OFF;
            else if (enable)
               st_nxt = ST_ON;
         end
         default: begin
            st_nxt  = ST_OFF;
            cnt_nxt = {CNT_W{1'b0}};
         end
      endcase
      // Switch-off from REGDL, V3DL or ON; without regulator hold all supplies drop in one edge
      if (~enable & (st_r >= ST_REGDL) & (st_r != ST_HOLD)) begin
         cnt_nxt = {CNT_W{1'b0}};
         if (ctrl_r[`KPL_CTRL_REG_HOLD] & bat_s_r)
            st_nxt = ST_HOLD;
         else
            st_nxt = ST_OFF;
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_r  <= ST_OFF;
         cnt_r <= {CNT_W{1'b0}};
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Relay follows the filtered key in BIAS and is held on from REGDL, so it leads every regulator
   assign o_main_relay_driver      = (st_r == ST_BIAS) ? key_flt :
                                     (st_r != ST_OFF) & (st_r != ST_HOLD);
   assign o_bias_en                = (st_r != ST_OFF);
   assign o_five_volt_regulator    = (st_r >= ST_V3DL);
   assign o_sensor_tracking_supply = (st_r >= ST_V3DL);
   assign o_three_volt_regulator   = (st_r >= ST_ON);

   // ****************
   // Reset output and key-return pulse
   // ****************
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         key_flt_d_r <= 1'b0;
         krr_pulse_r <= 1'b0;
         pulse_cnt_r <= {CNT_W{1'b0}};
      end else begin
         key_flt_d_r <= key_flt;
         if (~key_flt_d_r & key_flt & latch_act & cfg6_r[`KPL_CFG6_KRR_OPT] & (st_r == ST_ON)
             & ~krr_pulse_r) begin
            krr_pulse_r <= 1'b1;
            pulse_cnt_r <= {CNT_W{1'b0}};
         end else if (krr_pulse_r) begin
            if (pulse_cnt_r == PULSE_CYC[CNT_W-1:0] - 1'b1)
               krr_pulse_r <= 1'b0;
            else
               pulse_cnt_r <= pulse_cnt_r + 1'b1;
         end
      end
   end

   // Reset held while five-volt supply is absent or not good
   assign o_reset_n = o_five_volt_regulator & v5_s_r & ~krr_pulse_r
                      | (st_r == ST_HOLD) & v5_s_r;

   // ****************
   // Secure engine-off for injectors and starters
   // ****************
   kpl_seo_chan #(
      .ARM_CYC  (INJ_ARM_CYC),
      .HOLD_CYC (HOLD_CYC),
      .CNT_W    (CNT_W),
      .N        (4)
   ) u_inj (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_key_flt (key_flt),
      .i_wd_ok   (~wd_s_r),
      .i_seo_en  (cfg6_r[`KPL_CFG6_SEO_EN]),
      .i_drv_cmd (i_inj_cmd),
      .o_drv     (o_inj_drv),
      .o_armed   (),
      .o_holding (inj_hold)
   );

   // Only injector and starter groups go through the hold logic
   kpl_seo_chan #(
      .ARM_CYC  (STR_ARM_CYC),
      .HOLD_CYC (HOLD_CYC),
      .CNT_W    (CNT_W),
      .N        (2)
   ) u_str (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_key_flt (key_flt),
      .i_wd_ok   (~wd_s_r),
      .i_seo_en  (cfg6_r[`KPL_CFG6_SEO_EN]),
      .i_drv_cmd (i_str_cmd),
      .o_drv     (o_str_drv),
      .o_armed   (),
      .o_holding (str_hold)
   );

   // ****************
   // Register port
   // ****************
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ctrl_r <= `KPL_CTRL_RST;
         cfg6_r <= `KPL_CFG6_RST;
      end else if (i_wr) begin
         if (i_addr == `KPL_REG_CTRL)
            ctrl_r <= i_wdata;
         if (i_addr == `KPL_REG_CFG6)
            cfg6_r <= i_wdata;
      end
   end

   // Read data valid the cycle after the strobe only
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `KPL_REG_CTRL: o_rdata <= ctrl_r;
            `KPL_REG_CFG6: o_rdata <= cfg6_r;
            `KPL_REG_STAT: o_rdata <= {~o_reset_n, to_exp_r, o_three_volt_regulator,
                                       o_five_volt_regulator, o_main_relay_driver,
                                       enable, key_flt, key_raw};
            `KPL_REG_DRV:  o_rdata <= {2'h0, str_hold, inj_hold, 4'h0};
            default:       o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule

// ==== rtl/kpl_defs.vh ====
`ifndef KPL_DEFS_VH
`define KPL_DEFS_VH
// ****************
// Clock and timing
// ****************
`define KPL_CLK_HZ       100000000
`define KPL_KEY_FLT_MS   16
`define KPL_REG_DLY_US   1000
`define KPL_V3_DLY_US    1000
`define KPL_HOLD_MS      225
`define KPL_INJ_ARM_MS   225
`define KPL_STR_ARM_MS   600
`define KPL_PULSE_US     1000
`define KPL_CYC_PER_US   (`KPL_CLK_HZ / 1000000)
`define KPL_CYC_PER_MS   (`KPL_CLK_HZ / 1000)
// ****************
// Register map
// ****************
`define KPL_ADDR_W       4
`define KPL_REG_CTRL     4'h0
`define KPL_REG_CFG6     4'h1
`define KPL_REG_STAT     4'h2
`define KPL_REG_DRV      4'h3
// Control register fields
`define KPL_CTRL_LATCH_N 0
`define KPL_CTRL_REG_HOLD 1
`define KPL_CTRL_PERM    2
`define KPL_CTRL_TO_LSB  4
`define KPL_CTRL_RST     8'h01
// Config register six fields
`define KPL_CFG6_SEO_EN  0
`define KPL_CFG6_KRR_OPT 1
`define KPL_CFG6_RST     8'h00
`endif

// ==== rtl/kpl_sync_filter.v ====
`timescale 1ns/1ps
// ****************
// Two-stage synchroniser plus stability filter
// ****************
module kpl_sync_filter #(
   parameter integer FLT_CYC = 1600000,
   parameter integer CNT_W   = 21
) (
   input  wire i_ref_clk,
   input  wire i_sys_rst,
   input  wire i_async,
   output wire o_sync,
   output reg  o_filt
);
   reg             meta_r;
   reg             sync_r;
   reg [CNT_W-1:0] cnt_r;

   // Second stage only is read by logic
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end
   assign o_sync = sync_r;

   // Any bounce restarts the count, so the output moves only on a stable level
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         cnt_r  <= {CNT_W{1'b0}};
         o_filt <= 1'b0;
      end else if (sync_r == o_filt) begin
         cnt_r <= {CNT_W{1'b0}};
      end else if (cnt_r == FLT_CYC[CNT_W-1:0] - 1'b1) begin
         cnt_r  <= {CNT_W{1'b0}};
         o_filt <= sync_r;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule

// ==== rtl/kpl_seo_chan.v ====
`timescale 1ns/1ps
// ****************
// Secure engine-off hold for one driver group
// ****************
module kpl_seo_chan #(
   parameter integer ARM_CYC  = 22500000,
   parameter integer HOLD_CYC = 22500000,
   parameter integer CNT_W    = 27,
   parameter integer N        = 4
) (
   input  wire         i_ref_clk,
   input  wire         i_sys_rst,
   input  wire         i_key_flt,
   input  wire         i_wd_ok,
   input  wire         i_seo_en,
   input  wire [N-1:0] i_drv_cmd,
   output wire [N-1:0] o_drv,
   output wire         o_armed,
   output wire         o_holding
);
   reg [CNT_W-1:0] arm_cnt_r;
   reg             armed_r;
   reg [CNT_W-1:0] hold_cnt_r;
   reg             hold_r;
   reg             key_d_r;
   wire            qual = i_key_flt & i_wd_ok & (|i_drv_cmd);

   // Arming: key on, watchdog served, driver on, all together long enough
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         arm_cnt_r <= {CNT_W{1'b0}};
         armed_r   <= 1'b0;
      end else if (hold_r | (key_d_r & ~i_key_flt)) begin
         arm_cnt_r <= {CNT_W{1'b0}}; // re-arm needed after each event
         armed_r   <= 1'b0;
      end else if (~qual) begin
         arm_cnt_r <= {CNT_W{1'b0}};
      end else if (arm_cnt_r == ARM_CYC[CNT_W-1:0] - 1'b1) begin
         armed_r <= 1'b1;
      end else if (~armed_r) begin
         arm_cnt_r <= arm_cnt_r + 1'b1;
      end
   end

   // Hold timer on the reference clock, no software involvement
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         key_d_r    <= 1'b0;
         hold_r     <= 1'b0;
         hold_cnt_r <= {CNT_W{1'b0}};
      end else begin
         key_d_r <= i_key_flt;
         if (key_d_r & ~i_key_flt & armed_r & i_seo_en) begin
            hold_r     <= 1'b1;
            hold_cnt_r <= {CNT_W{1'b0}};
         end else if (hold_r & i_key_flt) begin
            hold_r <= 1'b0; // condition gone, no cut
         end else if (hold_r & (hold_cnt_r == HOLD_CYC[CNT_W-1:0] - 1'b1)) begin
            hold_r <= 1'b0;
         end else if (hold_r) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
         end
      end
   end

   // Software still switches drivers during hold
   // Key-fall edge term bridges the cycle before hold_r is set
   assign o_drv     = (i_key_flt | hold_r | (key_d_r & armed_r & i_seo_en)) ?
                      i_drv_cmd : {N{1'b0}};
   assign o_armed   = armed_r;
   assign o_holding = hold_r;
endmodule

// ==== verif/kpl_key_power_latch_assertions.sv ====
`timescale 1ns/1ps
// ****************
// Power sequencing checker
// ****************
module kpl_key_power_latch_assertions #(
   parameter integer KEY_FLT_CYC = 20,
   parameter integer REG_DLY_CYC = 10,
   parameter integer V3_DLY_CYC  = 10,
   parameter integer HOLD_CYC    = 30
) (
   input wire       i_ref_clk,
   input wire       i_sys_rst,
   input wire       i_key_above,
   input wire       i_battery_not_undervoltage,
   input wire       i_five_volt_not_undervoltage,
   input wire [3:0] i_inj_cmd,
   input wire [1:0] i_str_cmd,
   input wire       o_main_relay_driver,
   input wire       o_bias_en,
   input wire       o_five_volt_regulator,
   input wire       o_three_volt_regulator,
   input wire       o_sensor_tracking_supply,
   input wire       o_reset_n,
   input wire [3:0] o_inj_drv,
   input wire [1:0] o_str_drv
);
   reg [15:0] key_hi_r;
   reg [15:0] key_lo_r;
   reg [15:0] bat_r;
   reg [15:0] good_r;
   reg [15:0] bias_r;
   // Saturating, so a long idle never wraps back to a small count
   function [15:0] run_len(input [15:0] c, input b);
      run_len = b ? c + {15'h0, c != 16'hffff} : 16'h0;
   endfunction
   // Run lengths of the causes the outputs must wait for
   always @(posedge i_ref_clk) begin
      key_hi_r <= run_len(key_hi_r, i_key_above & !i_sys_rst);
      key_lo_r <= run_len(key_lo_r, !i_key_above & !i_sys_rst);
      bat_r    <= run_len(bat_r, i_battery_not_undervoltage & !i_sys_rst);
      good_r   <= run_len(good_r, i_five_volt_not_undervoltage & !i_sys_rst);
      bias_r   <= run_len(bias_r, o_bias_en & !i_sys_rst);
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   AST_RELAY_FIRST: assert property ($rose(o_five_volt_regulator) |->
      o_main_relay_driver && o_bias_en) else $error("relay late");
   AST_FILTER_ON: assert property ($rose(o_main_relay_driver) |->
      key_hi_r >= KEY_FLT_CYC) else $error("relay early");
   AST_FIVE_NEEDS_BATT: assert property ($rose(o_five_volt_regulator) |->
      bat_r >= REG_DLY_CYC) else $error("no battery");
   AST_REG_DELAY: assert property ($rose(o_five_volt_regulator) |->
      bias_r >= REG_DLY_CYC) else $error("five early");
   AST_TRACK_WITH_FIVE: assert property (
      o_sensor_tracking_supply == o_five_volt_regulator) else $error("tracking apart");
   AST_THREE_AFTER_GOOD: assert property ($rose(o_three_volt_regulator) |->
      good_r >= V3_DLY_CYC && o_five_volt_regulator) else $error("three early");
   AST_OFF_TOGETHER: assert property ($fell(o_five_volt_regulator) |->
      !o_three_volt_regulator && !o_sensor_tracking_supply) else $error("staggered");
   AST_OFF_AFTER_FILTER: assert property ($fell(o_main_relay_driver) |->
      key_lo_r >= KEY_FLT_CYC) else $error("off early");
   AST_RESET_NEEDS_FIVE: assert property (!o_five_volt_regulator |->
      !o_reset_n) else $error("reset free");
   AST_DRV_GATED: assert property (((o_inj_drv & ~i_inj_cmd) == 4'h0) &&
      ((o_str_drv & ~i_str_cmd) == 2'h0)) else $error("driver ungated");
   AST_HOLD_BOUND: assert property ((|o_inj_drv || |o_str_drv) |->
      key_lo_r <= KEY_FLT_CYC + HOLD_CYC + 6) else $error("hold too long");
endmodule

bind kpl_key_power_latch kpl_key_power_latch_assertions #(
   .KEY_FLT_CYC(KEY_FLT_CYC), .REG_DLY_CYC(REG_DLY_CYC), .V3_DLY_CYC(V3_DLY_CYC),
   .HOLD_CYC(HOLD_CYC)
) kpl_key_power_latch_assertions_i (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_key_above(i_key_above),
   .i_battery_not_undervoltage(i_battery_not_undervoltage),
   .i_five_volt_not_undervoltage(i_five_volt_not_undervoltage),
   .i_inj_cmd(i_inj_cmd), .i_str_cmd(i_str_cmd), .o_main_relay_driver(o_main_relay_driver),
   .o_bias_en(o_bias_en), .o_five_volt_regulator(o_five_volt_regulator),
   .o_three_volt_regulator(o_three_volt_regulator),
   .o_sensor_tracking_supply(o_sensor_tracking_supply), .o_reset_n(o_reset_n),
   .o_inj_drv(o_inj_drv), .o_str_drv(o_str_drv)
);

// ==== verif/kpl_key_relay_model.sv ====
`timescale 1ns/1ps
// ****************
// Key switch, battery and main relay
// ****************
module kpl_key_relay_model (
   input  wire i_ref_clk,
   input  wire i_key_on,
   input  wire i_perm,
   input  wire i_slow,
   input  wire i_relay,
   input  wire i_five,
   output wire o_key_above,
   output wire o_battery_not_undervoltage,
   output wire o_five_volt_not_undervoltage
);
   reg [7:0] relay_r = 8'h00;
   reg [3:0] five_r  = 4'h0;
   // Contact travel and regulator ramp, both lag their command
   always @(posedge i_ref_clk) begin
      relay_r <= {relay_r[6:0], i_relay};
      five_r  <= {five_r[2:0], i_five};
   end
   assign o_key_above = i_key_on;
   // Slow contacts give the sequencer a late battery to wait for
   assign o_battery_not_undervoltage = i_perm || (i_slow ? relay_r[7] : relay_r[1]);
   assign o_five_volt_not_undervoltage = five_r[3];
endmodule

// ==== verif/kpl_key_power_latch_tb.sv ====
`timescale 1ns/1ps
`include "kpl_defs.vh"
module kpl_key_power_latch_tb;
   localparam integer FLT  = 20;
   localparam integer HOLD = 30;
   localparam integer TOU  = 50;
   localparam integer PUL  = 8;
   reg        clk = 1'b0;
   reg        rst = 1'b1;
   reg        key_on = 1'b0;
   reg        perm = 1'b0;
   reg        slow = 1'b0;
   reg        wd_err = 1'b0;
   reg        wr = 1'b0;
   reg        rd = 1'b0;
   reg  [3:0] inj_cmd = 4'h0;
   reg  [3:0] addr = 4'h0;
   reg  [1:0] str_cmd = 2'h0;
   reg  [7:0] wdata = 8'h00;
   wire       key_above, bat_ok, five_ok, relay, bias, five, three, track, rst_n;
   wire [7:0] rdata;
   wire [3:0] inj;
   wire [1:0] str;
   integer    mismatches = 0;
   integer    comparisons = 0;
   kpl_key_power_latch #(
      .KEY_FLT_CYC(FLT), .REG_DLY_CYC(10), .V3_DLY_CYC(10), .HOLD_CYC(HOLD),
      .INJ_ARM_CYC(20), .STR_ARM_CYC(40), .PULSE_CYC(PUL), .TO_UNIT_CYC(TOU)
   ) kpl_key_power_latch_i (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_key_above(key_above),
      .i_battery_not_undervoltage(bat_ok), .i_five_volt_not_undervoltage(five_ok),
      .i_wd_err_ge4(wd_err), .i_inj_cmd(inj_cmd), .i_str_cmd(str_cmd), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_main_relay_driver(relay),
      .o_bias_en(bias), .o_five_volt_regulator(five), .o_three_volt_regulator(three),
      .o_sensor_tracking_supply(track), .o_reset_n(rst_n), .o_inj_drv(inj), .o_str_drv(str)
   );
   kpl_key_relay_model kpl_key_relay_model_i (
      .i_ref_clk(clk), .i_key_on(key_on), .i_perm(perm), .i_slow(slow), .i_relay(relay),
      .i_five(five), .o_key_above(key_above), .o_battery_not_undervoltage(bat_ok),
      .o_five_volt_not_undervoltage(five_ok)
   );
   // 100 MHz reference
   always #5 clk = ~clk;
   // ****************
   // Shared tasks
   // ****************
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, mismatches);
         if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
         end else begin
            $display("MISMATCHES SEEN");
         end
         $finish;
      end
   endtask
   task check(input string name, input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task wr_reg(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk);
         wr    <= 1'b1;
         addr  <= a;
         wdata <= d;
         @(posedge clk);
         wr    <= 1'b0;
      end
   endtask
   // Data stands only in the cycle after the strobe
   task rd_chk(input string name, input [3:0] a, input [7:0] m, input [7:0] e);
      begin
         @(posedge clk);
         rd   <= 1'b1;
         addr <= a;
         @(posedge clk);
         rd   <= 1'b0;
         #1;
         check(name, rdata & m, e);
      end
   endtask
   // Bounded wait on one output; n returns the cycles spent
   task wait_for(input integer which, input lvl, input integer max, output integer n);
      reg v;
      begin
         n = 0;
         v = ~lvl;
         while (v !== lvl && n <= max) begin
            @(posedge clk);
            #1;
            n = n + 1;
            case (which)
               0: v = relay;
               1: v = five;
               2: v = three;
               3: v = |inj;
               default: v = rst_n;
            endcase
         end
         if (v !== lvl) begin
            mismatches = mismatches + 1;
            $display("wrong value wait %0d expected %b seen %b", which, lvl, v);
            close_out;
         end
      end
   endtask
   task power_up;
      integer n;
      begin
         key_on <= 1'b1;
         wait_for(0, 1'b1, FLT + 10, n);
         check("filter", n >= FLT, 1'b1);
         check("early five", five, 1'b0);
         wait_for(1, 1'b1, 40, n);
         check("tracking", track, 1'b1);
         check("early three", three, 1'b0);
         wait_for(2, 1'b1, 40, n);
         check("three delay", n >= 10, 1'b1);
         wait_for(4, 1'b1, 60, n);
      end
   endtask
   // ****************
   // Scenarios
   // ****************
   task t_regs;
      begin
         rd_chk("ctrl", `KPL_REG_CTRL, 8'hff, `KPL_CTRL_RST);
         rd_chk("cfg6", `KPL_REG_CFG6, 8'hff, `KPL_CFG6_RST);
         wr_reg(`KPL_REG_STAT, 8'hff);
         wr_reg(4'hf, 8'hff);
         // Powered down, so only the reset-asserted bit is up
         rd_chk("status", `KPL_REG_STAT, 8'hff, 8'h80);
         rd_chk("unmapped", 4'hf, 8'hff, 8'h00);
      end
   endtask
   task t_supply(input p);
      integer n;
      begin
         perm <= p;
         slow <= !p;
         wr_reg(`KPL_REG_CTRL, {5'h00, p, 2'b01});
         key_on <= 1'b1;
         @(posedge clk);
         rd_chk("raw key", `KPL_REG_STAT, 8'h03, 8'h01);
         // Short key blip: filter restarts, so power_up times from a clean edge
         key_on <= 1'b0;
         repeat (3) @(posedge clk);
         power_up;
         rd_chk("on status", `KPL_REG_STAT, 8'h7f, 8'h3f);
         key_on <= 1'b0;
         wait_for(0, 1'b0, FLT + 10, n);
         check("off delay", n >= FLT, 1'b1);
         check("all off", {three, track, five}, 3'h0);
      end
   endtask
   task t_latch;
      integer n;
      begin
         power_up;
         wr_reg(`KPL_REG_CTRL, 8'h00);
         key_on <= 1'b0;
         repeat (FLT + 40) @(posedge clk);
         #1;
         check("latched", {relay, five}, 2'h3);
         wr_reg(`KPL_REG_CTRL, 8'h01);
         wait_for(0, 1'b0, 8, n);
         power_up;
         wr_reg(`KPL_REG_CTRL, 8'h10);
         key_on <= 1'b0;
         wait_for(0, 1'b0, FLT + TOU + 10, n);
         check("timeout", n > FLT + 10, 1'b1);
         wr_reg(`KPL_REG_CTRL, 8'h01);
      end
   endtask
   task t_hold;
      integer n;
      begin
         perm <= 1'b1;
         slow <= 1'b0;
         wr_reg(`KPL_REG_CTRL, 8'h07);
         power_up;
         key_on <= 1'b0;
         wait_for(0, 1'b0, FLT + 10, n);
         repeat (20) @(posedge clk);
         #1;
         check("held", {three, five, rst_n}, 3'h7);
         wr_reg(`KPL_REG_CTRL, 8'h05);
         wait_for(1, 1'b0, 8, n);
         wr_reg(`KPL_REG_CTRL, 8'h01);
         perm <= 1'b0;
      end
   endtask
   task t_seo(input wd, input hold);
      integer n;
      begin
         wr_reg(`KPL_REG_CFG6, 8'h01);
         power_up;
         wr_reg(`KPL_REG_CTRL, 8'h00);
         wd_err  <= wd;
         inj_cmd <= 4'hf;
         str_cmd <= 2'h3;
         repeat (60) @(posedge clk);
         key_on  <= 1'b0;
         repeat (FLT + 10) @(posedge clk);
         inj_cmd <= 4'he;
         @(posedge clk);
         #1;
         check("inj hold", inj, hold ? 4'he : 4'h0);
         check("str hold", str, hold ? 2'h3 : 2'h0);
         check("relay kept", {relay, three}, 2'h3);
         wait_for(3, 1'b0, HOLD + 4, n);
         @(posedge clk);
         #1;
         check("str cut", str, 2'h0);
         inj_cmd <= 4'h0;
         str_cmd <= 2'h0;
         wd_err  <= 1'b0;
         wr_reg(`KPL_REG_CTRL, 8'h01);
         wr_reg(`KPL_REG_CFG6, 8'h00);
         wait_for(0, 1'b0, 8, n);
      end
   endtask
   task t_key_return;
      integer n;
      begin
         wr_reg(`KPL_REG_CFG6, 8'h02);
         power_up;
         wr_reg(`KPL_REG_CTRL, 8'h00);
         key_on <= 1'b0;
         repeat (FLT + 10) @(posedge clk);
         key_on <= 1'b1;
         wait_for(4, 1'b0, FLT + 8, n);
         wait_for(4, 1'b1, PUL + 4, n);
         check("pulse", n >= PUL - 1, 1'b1);
         wr_reg(`KPL_REG_CTRL, 8'h01);
         key_on <= 1'b0;
         wait_for(0, 1'b0, FLT + 10, n);
      end
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      t_regs;
      t_supply(1'b0);
      t_supply(1'b1);
      t_latch;
      t_hold;
      t_seo(1'b1, 1'b0);
      t_seo(1'b0, 1'b1);
      t_key_return;
      close_out;
   end
endmodule
